// [src/pslt_consts.svh]
// Register offsets, field positions, reset values and timing counts for the
// port split link timeout block.
// Assumes a 25 MHz core clock; included by every design file that needs it.
`ifndef PSLT_CONSTS_SVH
`define PSLT_CONSTS_SVH

// ==========================================================================
// Register offsets (16-bit internal register address space)
`define PSLT_OFS_PORT_EN 16'h3c48
`define PSLT_OFS_GLOBAL_EN 16'h4141
`define PSLT_OFS_P3_PIN_SEL 16'h416e
`define PSLT_OFS_P4_PIN_SEL 16'h416f
`define PSLT_OFS_TIMEOUT 16'h4171
`define PSLT_OFS_LOW_TIME 16'h4176

// ==========================================================================
// Field positions
`define PSLT_BIT_PORT3_EN 5
`define PSLT_BIT_PORT4_EN 6
`define PSLT_BIT_GLOBAL_EN 0

// ==========================================================================
// Reset values
`define PSLT_RST_PORT_EN 8'h00
`define PSLT_RST_GLOBAL_EN 8'h00
`define PSLT_RST_P3_PIN_SEL 8'h42
`define PSLT_RST_P4_PIN_SEL 8'h06
`define PSLT_RST_TIMEOUT 8'h05
`define PSLT_RST_LOW_TIME 8'h05

// ==========================================================================
// Pin select codes
`define PSLT_P3_SEL_A 8'h42
`define PSLT_P3_SEL_B 8'h05
`define PSLT_P4_SEL_A 8'h06
`define PSLT_P4_SEL_B 8'h04

// ==========================================================================
// Link training state codes that count as stuck
`define PSLT_STUCK_LO 4'h4
`define PSLT_STUCK_HI 4'h9

// ==========================================================================
// Timing: clock rate, unit tick and times in ms
`define PSLT_CLK_HZ 25000000
`define PSLT_TICK_MS 1
`define PSLT_TICK_CYC ((`PSLT_CLK_HZ / 1000) * `PSLT_TICK_MS)
`define PSLT_LOW_MIN_MS 350
`define PSLT_LOW_STEP_MS 10
`define PSLT_TO_100_MS 100
`define PSLT_TO_250_MS 250
`define PSLT_TO_500_MS 500
`define PSLT_TO_750_MS 750
`define PSLT_TO_1000_MS 1000
`define PSLT_TO_2000_MS 2000

`endif

// [src/pslt_pkg.sv]
// Types shared by the port split link timeout block.
// Assumes nothing of its surroundings.
package pslt_pkg;

    // ======================================================================
    // Per-port supervisor states, one-hot
    typedef enum logic [2:0] {
        PSLT_ST_OFF = 3'b001,
        PSLT_ST_WATCH = 3'b010,
        PSLT_ST_LOW = 3'b100
    } pslt_state_t;

endpackage

// [src/pslt_tick.sv]
// Millisecond tick generator for the split supervisors.
// Assumes the 25 MHz core clock and the common clock enable.
`timescale 1ns/1ps
`include "pslt_consts.svh"

module pslt_tick
    import pslt_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    input wire logic clk_en,
    // Tick out
    output logic tick_ms
);

    logic [14:0] cnt_q, cnt_d;
    logic tick_q, tick_d;

    // ======================================================================
    // Divider: one pulse every TICK_CYC enabled cycles
    always_comb begin
        tick_d = 1'b0;
        cnt_d = cnt_q + 15'h0001;
        if (cnt_q == 15'((`PSLT_TICK_CYC) - 1)) begin
            cnt_d = 15'h0000;
            tick_d = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= 15'h0000;
            tick_q <= 1'b0;
        end else if (clk_en) begin
            cnt_q <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tick_ms = tick_q & clk_en;

endmodule

// [src/pslt_port.sv]
// One split port supervisor: watches the link state and toggles split power.
// Assumes a synchronised link state and a one-cycle millisecond tick.
`timescale 1ns/1ps
`include "pslt_consts.svh"

module pslt_port
    import pslt_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic tick_ms,
    // Configuration
    input wire logic split_on,
    input wire logic [2:0] timeout_sel,
    input wire logic [7:0] low_time,
    input wire logic [3:0] link_state,
    // Status
    output logic power_on,
    output logic toggling,
    output logic timeout_evt
);

    pslt_state_t st_q, st_d;
    logic [11:0] ms_q, ms_d;
    logic [3:0] last_q, last_d;
    logic evt_d, evt_q;
    logic [11:0] limit;
    logic [11:0] low_ms;
    logic stuck;

    // Timeout select to milliseconds; zero means never toggle
    function automatic logic [11:0] to_ms(input logic [2:0] sel);
        case (sel)
            3'h1: to_ms = 12'(`PSLT_TO_100_MS);
            3'h2: to_ms = 12'(`PSLT_TO_250_MS);
            3'h3: to_ms = 12'(`PSLT_TO_500_MS);
            3'h4: to_ms = 12'(`PSLT_TO_750_MS);
            3'h5: to_ms = 12'(`PSLT_TO_1000_MS);
            3'h6: to_ms = 12'(`PSLT_TO_2000_MS);
            default: to_ms = 12'h000; // Reserved behaves as disabled
        endcase
    endfunction

    assign limit = to_ms(timeout_sel);
    assign low_ms = 12'(`PSLT_LOW_MIN_MS) + 12'(low_time) * 12'(`PSLT_LOW_STEP_MS);
    assign stuck = (link_state >= `PSLT_STUCK_LO) && (link_state <= `PSLT_STUCK_HI);

    // ======================================================================
    // Supervisor next state
    always_comb begin
        st_d = st_q;
        ms_d = ms_q;
        last_d = link_state;
        evt_d = 1'b0;
        case (st_q)
            PSLT_ST_OFF: begin
                ms_d = 12'h000;
                if (split_on) begin
                    st_d = PSLT_ST_WATCH;
                end
            end
            PSLT_ST_WATCH: begin
                if (!split_on) begin
                    st_d = PSLT_ST_OFF;
                    ms_d = 12'h000;
                end else if (!stuck || link_state != last_q || limit == 12'h000) begin
                    ms_d = 12'h000;
                end else if (tick_ms) begin
                    if (ms_q + 12'h001 >= limit) begin
                        st_d = PSLT_ST_LOW;
                        ms_d = 12'h000;
                        evt_d = 1'b1;
                    end else begin
                        ms_d = ms_q + 12'h001;
                    end
                end
            end
            PSLT_ST_LOW: begin
                // Low time runs out even if splitting is dropped meanwhile
                if (tick_ms) begin
                    if (ms_q + 12'h001 >= low_ms) begin
                        st_d = split_on ? PSLT_ST_WATCH : PSLT_ST_OFF;
                        ms_d = 12'h000;
                    end else begin
                        ms_d = ms_q + 12'h001;
                    end
                end
            end
            default: begin
                st_d = PSLT_ST_OFF;
                ms_d = 12'h000;
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_q <= PSLT_ST_OFF;
            ms_q <= 12'h000;
            last_q <= 4'h0;
            evt_q <= 1'b0;
        end else if (clk_en) begin
            st_q <= st_d;
            ms_q <= ms_d;
            last_q <= last_d;
            evt_q <= evt_d;
        end
    end

    // Split power is high only while watching; it is low when off and during the reset pulse
    assign power_on = (st_q == PSLT_ST_WATCH);
    assign toggling = (st_q == PSLT_ST_LOW);
    assign timeout_evt = evt_q;

endmodule

// [src/pslt_top.sv]
// Port split control for downstream ports 3 and 4 of the hub.
// Assumes a byte-wide internal register port driven by the configuration
// loader or SMBus agent, link state codes from the SuperSpeed ports, and
// one 25 MHz core clock with the hub's asynchronous active-low reset.
// Register map, one byte each:
// Port enables at 0x3c48, bit 0 stays 0
// Global enable at 0x4141, bit 0
// Port 3 pin select at 0x416e
// Port 4 pin select at 0x416f
// Stuck link timeout code at 0x4171
// Split pin low time at 0x4176
//
// Pin bits: 0 port 3 A, 1 port 4 A,
// Then 2 port 3 B, 3 port 4 B.
// Output enables are low while driving.
//
// Timeout codes: 1 100 ms, 2 250 ms,
// Then 3 500 ms, 4 750 ms, 5 1 s, 6 2 s;
// Codes 0 and 7 disable the toggle.
// Low time: 350 ms plus 10 ms a count.
// Clock enable low freezes all state.
`timescale 1ns/1ps
`include "pslt_consts.svh"

module pslt_top
    import pslt_pkg::*;
(
    // Clock, reset and enable
    input wire logic clk,
    input wire logic nrst,
    input wire logic clk_en,
    // Internal register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_hit,
    // Link training state status per port, from the link clock domain
    input wire logic [3:0] link_state_p3,
    input wire logic [3:0] link_state_p4,
    // Ordinary port power requests from the hub core
    input wire logic port_power_req_p3,
    input wire logic port_power_req_p4,
    // Pins
    output logic port_power_ctl_pin_p3,
    output logic port_power_ctl_pin_p4,
    output logic [3:0] gpio_out,
    output logic [3:0] gpio_split_oe,
    // Status
    output logic [1:0] split_active,
    output logic [1:0] split_reset_evt
);

    // Reserved bits are never stored
    // Registers
    logic [7:0] port_en_q, port_en_d;
    logic [7:0] global_en_q, global_en_d;
    logic [7:0] p3_sel_q, p3_sel_d;
    logic [7:0] p4_sel_q, p4_sel_d;
    logic [2:0] timeout_q, timeout_d;
    logic [7:0] low_time_q, low_time_d;
    logic [7:0] rdata_q, rdata_d;
    logic hit_q, hit_d;

    // Link codes arrive unsynchronised
    // Synchronisers for the link state codes
    logic [3:0] ls_meta_q [2];
    logic [3:0] ls_sync_q [2];
    logic [3:0] ls_raw [2];

    // Each pin and status output leaves one of these
    // Pin outputs
    logic [1:0] ctl_q, ctl_d;
    logic [3:0] gpo_q, gpo_d;
    logic [3:0] goe_n_q, goe_n_d;
    logic [1:0] act_q, act_d;
    logic [1:0] evt_q, evt_d;

    // Nets between registers and ports
    logic tick_ms;
    logic [1:0] split_on;
    logic [1:0] power_on;
    logic [1:0] port_evt;
    logic [1:0] toggling;
    logic [1:0] sel_ok;

    // Unknown codes leave a port unsplit,
    // so no stray pin is ever claimed
    // Which of the four split GPIOs a select code drives (one-hot,
    // 0: port3 A, 1: port4 A, 2: port3 B, 3: port4 B); zero if unknown
    function automatic logic [3:0] pin_of(input logic port4, input logic [7:0] sel);
        pin_of = 4'h0;
        if (!port4) begin
            if (sel == `PSLT_P3_SEL_A) pin_of = 4'h1;
            else if (sel == `PSLT_P3_SEL_B) pin_of = 4'h4;
        end else begin
            if (sel == `PSLT_P4_SEL_A) pin_of = 4'h2;
            else if (sel == `PSLT_P4_SEL_B) pin_of = 4'h8;
        end
    endfunction

    // No hit for unmapped addresses
    // Read decode, shared by data and hit
    function automatic logic [8:0] rd_of(input logic [15:0] a, input logic [7:0] pe,
                                         input logic [7:0] ge, input logic [7:0] s3,
                                         input logic [7:0] s4, input logic [2:0] to,
                                         input logic [7:0] lt);
        case (a)
            `PSLT_OFS_PORT_EN: rd_of = {1'b1, pe};
            `PSLT_OFS_GLOBAL_EN: rd_of = {1'b1, ge};
            `PSLT_OFS_P3_PIN_SEL: rd_of = {1'b1, s3};
            `PSLT_OFS_P4_PIN_SEL: rd_of = {1'b1, s4};
            `PSLT_OFS_TIMEOUT: rd_of = {1'b1, 5'h00, to};
            `PSLT_OFS_LOW_TIME: rd_of = {1'b1, lt};
            default: rd_of = 9'h000; // Unmapped reads as zero
        endcase
    endfunction

    // ======================================================================
    // Register writes
    // Writes land on the next edge
    // Read answer stands for one cycle
    always_comb begin
        port_en_d = port_en_q;
        global_en_d = global_en_q;
        p3_sel_d = p3_sel_q;
        p4_sel_d = p4_sel_q;
        timeout_d = timeout_q;
        low_time_d = low_time_q;
        if (reg_wr) begin
            case (reg_addr)
                `PSLT_OFS_PORT_EN: port_en_d = {reg_wdata[7:1], 1'b0};
                `PSLT_OFS_GLOBAL_EN: global_en_d = {7'h00, reg_wdata[0]};
                `PSLT_OFS_P3_PIN_SEL: p3_sel_d = reg_wdata;
                `PSLT_OFS_P4_PIN_SEL: p4_sel_d = reg_wdata;
                `PSLT_OFS_TIMEOUT: timeout_d = reg_wdata[2:0];
                `PSLT_OFS_LOW_TIME: low_time_d = reg_wdata;
                default: ;
            endcase
        end
        {hit_d, rdata_d} = reg_rd ? rd_of(reg_addr, port_en_q, global_en_q, p3_sel_q,
                                          p4_sel_q, timeout_q, low_time_q) : 9'h000;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            // Selects wake up on option A
            port_en_q <= `PSLT_RST_PORT_EN;
            global_en_q <= `PSLT_RST_GLOBAL_EN;
            p3_sel_q <= `PSLT_RST_P3_PIN_SEL;
            p4_sel_q <= `PSLT_RST_P4_PIN_SEL;
            timeout_q <= 3'(`PSLT_RST_TIMEOUT);
            low_time_q <= `PSLT_RST_LOW_TIME;
            rdata_q <= 8'h00;
            hit_q <= 1'b0;
        end else if (clk_en) begin
            port_en_q <= port_en_d;
            global_en_q <= global_en_d;
            p3_sel_q <= p3_sel_d;
            p4_sel_q <= p4_sel_d;
            timeout_q <= timeout_d;
            low_time_q <= low_time_d;
            rdata_q <= rdata_d;
            hit_q <= hit_d;
        end
    end

    // Split needs both enables and a pin
    // Only ports 3 and 4 have an enable bit that reaches the logic
    assign split_on[0] = global_en_q[`PSLT_BIT_GLOBAL_EN]
                         & port_en_q[`PSLT_BIT_PORT3_EN];
    assign split_on[1] = global_en_q[`PSLT_BIT_GLOBAL_EN]
                         & port_en_q[`PSLT_BIT_PORT4_EN];
    // Valid select per port
    assign sel_ok[0] = |pin_of(1'b0, p3_sel_q);
    assign sel_ok[1] = |pin_of(1'b1, p4_sel_q);
    // Raw codes as an array
    assign ls_raw[0] = link_state_p3;
    assign ls_raw[1] = link_state_p4;

    // ======================================================================
    // Link state synchronisers and per-port supervisors
    // Off releases the pin; watch holds it
    // high and counts stuck milliseconds;
    // low drives it low for the set time.
    // A shared tick costs up to 1 ms.
    // Shared millisecond tick
    pslt_tick u_tick (
        .clk(clk),
        .nrst(nrst),
        .clk_en(clk_en),
        .tick_ms(tick_ms)
    );

    // Sync and supervisor per port
    for (genvar p = 0; p < 2; p++) begin : g_port
        // Code may tear across bits for a cycle; that only restarts the timer
        // Only the second flop is read
        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                ls_meta_q[p] <= 4'h0;
                ls_sync_q[p] <= 4'h0;
            end else if (clk_en) begin
                ls_meta_q[p] <= ls_raw[p];
                ls_sync_q[p] <= ls_meta_q[p];
            end
        end

        // Supervisor for this port
        pslt_port u_port (
            .clk(clk),
            .nrst(nrst),
            .clk_en(clk_en),
            .tick_ms(tick_ms),
            .split_on(split_on[p] & sel_ok[p]),
            .timeout_sel(timeout_q),
            .low_time(low_time_q),
            .link_state(ls_sync_q[p]),
            .power_on(power_on[p]),
            .toggling(toggling[p]),
            .timeout_evt(port_evt[p])
        );
    end

    // ======================================================================
    // Pin drive
    // If its enables drop mid-toggle, a pin stays claimed
    // to the end of the power cycle, then is released
    always_comb begin
        logic [3:0] m3;
        logic [3:0] m4;
        m3 = pin_of(1'b0, p3_sel_q);
        m4 = pin_of(1'b1, p4_sel_q);
        // Ordinary power pins follow the hub core whether split or not
        ctl_d = {port_power_req_p4, port_power_req_p3};
        // Released pins idle low, oe high
        gpo_d = 4'h0;
        goe_n_d = 4'hf;
        // Split pin only claims its GPIO while active or mid-toggle
        if ((split_on[0] && sel_ok[0]) || toggling[0]) begin
            gpo_d = gpo_d | (m3 & {4{power_on[0]}});
            goe_n_d = goe_n_d & ~m3;
        end
        if ((split_on[1] && sel_ok[1]) || toggling[1]) begin
            gpo_d = gpo_d | (m4 & {4{power_on[1]}});
            goe_n_d = goe_n_d & ~m4;
        end
        act_d = split_on & sel_ok;
        // Events line up with the pin
        evt_d = port_evt;
    end

    // Overcurrent stays on the port pin
    // No overcurrent input exists for the split pins by design
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctl_q <= 2'h0;
            gpo_q <= 4'h0;
            goe_n_q <= 4'hf;
            act_q <= 2'h0;
            evt_q <= 2'h0;
        end else if (clk_en) begin
            ctl_q <= ctl_d;
            gpo_q <= gpo_d;
            goe_n_q <= goe_n_d;
            act_q <= act_d;
            evt_q <= evt_d;
        end
    end

    // Straight register copies
    assign reg_rdata = rdata_q;
    assign reg_hit = hit_q;
    assign port_power_ctl_pin_p3 = ctl_q[0];
    assign port_power_ctl_pin_p4 = ctl_q[1];
    assign gpio_out = gpo_q;
    assign gpio_split_oe = goe_n_q;
    assign split_active = act_q;
    assign split_reset_evt = evt_q;

endmodule

// [tb/pslt_split_chk.sv]
// Concurrent checks on the port split block's register port and pins.
// Assumes it is bound onto pslt_top and shares its single core clock.
`timescale 1ns/1ps
`include "pslt_consts.svh"

module pslt_split_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    input wire logic clk_en,
    // Register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_hit,
    // Power and split pins
    input wire logic port_power_req_p3,
    input wire logic port_power_ctl_pin_p3,
    input wire logic [3:0] gpio_out,
    input wire logic [3:0] gpio_split_oe,
    input wire logic [1:0] split_active,
    input wire logic [1:0] split_reset_evt
);
    // ==================================================================
    // Clocking and request sequences
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    sequence s_rd_en;
        clk_en && reg_rd && reg_addr == `PSLT_OFS_PORT_EN;
    endsequence
    sequence s_rd_glb;
        clk_en && reg_rd && reg_addr == `PSLT_OFS_GLOBAL_EN;
    endsequence
    sequence s_rd_to;
        clk_en && reg_rd && reg_addr == `PSLT_OFS_TIMEOUT;
    endsequence
    // Write that clears the global enable, then two running cycles to settle
    sequence s_glb_off;
        clk_en && reg_wr && reg_addr == `PSLT_OFS_GLOBAL_EN && !reg_wdata[0] ##1 clk_en[*2];
    endsequence

    // ==================================================================
    // Properties
    property p_ctl_follow;
        clk_en |=> port_power_ctl_pin_p3 == $past(port_power_req_p3);
    endproperty
    property p_en_bit0;
        s_rd_en |=> reg_hit && !reg_rdata[0];
    endproperty
    property p_glb_rsv;
        s_rd_glb |=> reg_hit && reg_rdata[7:1] == 7'h00;
    endproperty
    property p_to_rsv;
        s_rd_to |=> reg_hit && reg_rdata[7:3] == 5'h00;
    endproperty
    property p_glb_off;
        s_glb_off |=> split_active == 2'b00;
    endproperty
    // A settled port 3 split must drive one of its two pins
    property p_oe_act;
        split_active[0] && $past(split_active[0]) |-> !(gpio_split_oe[0] && gpio_split_oe[2]);
    endproperty
    property p_p3_one;
        $onehot0(~{gpio_split_oe[2], gpio_split_oe[0]});
    endproperty
    property p_p4_one;
        $onehot0(~{gpio_split_oe[3], gpio_split_oe[1]});
    endproperty
    property p_evt_pulse;
        split_reset_evt[0] && clk_en |=> !split_reset_evt[0];
    endproperty
    property p_evt_low;
        split_reset_evt[0] |-> ##[0:2] (gpio_out[0] | gpio_out[2]) == 1'b0;
    endproperty

    // ==================================================================
    // Assertions
    a_ctl_follow: assert property (p_ctl_follow)
        else $error("port power pin does not follow request");
    a_en_bit0: assert property (p_en_bit0)
        else $error("enable register bit 0 not read as zero");
    a_glb_rsv: assert property (p_glb_rsv)
        else $error("global enable reserved bits not zero");
    a_to_rsv: assert property (p_to_rsv)
        else $error("timeout reserved bits not zero");
    a_glb_off: assert property (p_glb_off)
        else $error("split stays active after global disable");
    a_oe_act: assert property (p_oe_act)
        else $error("active port 3 split drives no pin");
    a_p3_one: assert property (p_p3_one)
        else $error("both port 3 split pins driven");
    a_p4_one: assert property (p_p4_one)
        else $error("both port 4 split pins driven");
    a_evt_pulse: assert property (p_evt_pulse)
        else $error("reset event longer than one cycle");
    a_evt_low: assert property (p_evt_low)
        else $error("split pin not low after reset event");
endmodule

bind pslt_top pslt_split_chk u_chk (
    .clk(clk), .nrst(nrst), .clk_en(clk_en), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
    .port_power_req_p3(port_power_req_p3), .port_power_ctl_pin_p3(port_power_ctl_pin_p3),
    .gpio_out(gpio_out), .gpio_split_oe(gpio_split_oe), .split_active(split_active),
    .split_reset_evt(split_reset_evt)
);

// [tb/pslt_ss_dev.sv]
// Embedded SuperSpeed device model as the hub sees it through link state.
// Assumes power is the split pin level while the pin is driven.
`timescale 1ns/1ps

module pslt_ss_dev (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Split power and behaviour mode
    input wire logic power,
    input wire logic stuck,
    // Link training state status
    output logic [3:0] link_state
);
    logic [1:0] step_q;
    // Free-running step keeps a healthy link hopping between codes
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            step_q <= 2'h0;
        end else begin
            step_q <= step_q + 2'h1;
        end
    end
    // Unpowered or hung device parks the link in a stuck code
    assign link_state = !power ? 4'h5 : (stuck ? 4'h7 : {2'b00, step_q});
endmodule

// [tb/port_split_link_timeout_power_bench.sv]
// Self-checking bench for the port split block with two device models.
// Assumes the design, checker and model files are compiled first.
`timescale 1ns/1ps
`include "pslt_consts.svh"

`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin failures++; \
$display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module port_split_link_timeout_power_bench;
    // ==================================================================
    // Signals
    logic clk = 1'b0, nrst = 1'b0, clk_en = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic req3 = 1'b0, req4 = 1'b0, st3 = 1'b0, st4 = 1'b0, g, hit_d, ctl3, ctl4, hit_raw;
    logic [15:0] reg_addr = 16'h0000;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, rd_d, en, s3, s4;
    logic [3:0] ls3, ls4, gpio_out, oe;
    logic [1:0] act, evt;
    int failures = 0, check_count = 0, evt_seen = 0;
    logic [15:0] ofs [6] = '{16'h3c48, 16'h4141, 16'h416e, 16'h416f, 16'h4171, 16'h4176};
    logic [7:0] rst_v [6] = '{8'h00, 8'h00, 8'h42, 8'h06, 8'h05, 8'h05};
    logic [7:0] rb_v [6] = '{8'hfe, 8'h01, 8'hff, 8'hff, 8'h07, 8'hff};
    logic [7:0] sel3 [3] = '{8'h42, 8'h05, 8'h11};
    logic [7:0] sel4 [3] = '{8'h06, 8'h04, 8'h33};

    // ==================================================================
    // Clock, design and device models
    initial begin
        forever #20 clk = ~clk;
    end
    pslt_top u_dut (
        .clk(clk), .nrst(nrst), .clk_en(clk_en), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(hit_raw),
        .link_state_p3(ls3), .link_state_p4(ls4), .port_power_req_p3(req3),
        .port_power_req_p4(req4), .port_power_ctl_pin_p3(ctl3), .port_power_ctl_pin_p4(ctl4),
        .gpio_out(gpio_out), .gpio_split_oe(oe), .split_active(act), .split_reset_evt(evt)
    );
    pslt_ss_dev u_dev3 (.clk(clk), .nrst(nrst), .stuck(st3), .link_state(ls3),
        .power((gpio_out[0] & ~oe[0]) | (gpio_out[2] & ~oe[2])));
    pslt_ss_dev u_dev4 (.clk(clk), .nrst(nrst), .stuck(st4), .link_state(ls4),
        .power((gpio_out[1] & ~oe[1]) | (gpio_out[3] & ~oe[3])));
    // Count every reset event; none may fire well before any timeout
    always @(posedge clk) begin
        if (nrst && evt != 2'b00) evt_seen++;
    end

    // ==================================================================
    // Register port tasks and expectations
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        rd_d = reg_rdata;
        hit_d = hit_raw;
    endtask
    task automatic chk_reg(input logic [15:0] a, input logic [7:0] e);
        rd(a);
        `CHK(rd_d, e)
        `CHK(hit_d, 1'b1)
    endtask
    function automatic logic [1:0] exp_act(input logic gl, input logic [7:0] e, a3, a4);
        exp_act[0] = gl & e[5] & (a3 == 8'h42 || a3 == 8'h05);
        exp_act[1] = gl & e[6] & (a4 == 8'h06 || a4 == 8'h04);
    endfunction
    function automatic logic [3:0] exp_oe(input logic [1:0] a, input logic [7:0] a3, a4);
        exp_oe = 4'hf;
        if (a[0]) exp_oe[(a3 == 8'h42) ? 0 : 2] = 1'b0;
        if (a[1]) exp_oe[(a4 == 8'h06) ? 1 : 3] = 1'b0;
    endfunction
    task automatic summarize;
        $display("checks=%0d failures=%0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ==================================================================
    // Main sequence
    initial begin
        void'($urandom(2408));
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        #1;
        `CHK({oe, gpio_out, act}, {4'hf, 4'h0, 2'b00})
        for (int i = 0; i < 6; i++) begin
            chk_reg(ofs[i], rst_v[i]);
        end
        for (int i = 0; i < 6; i++) begin
            wr(ofs[i], 8'hff);
            chk_reg(ofs[i], rb_v[i]);
        end
        // A port 2 select would sit here; only ports 3 and 4 can split
        rd(16'h416d);
        `CHK({rd_d, hit_d}, 9'h000)
        // Frozen clock enable must swallow a write
        @(posedge clk);
        clk_en <= 1'b0;
        wr(`PSLT_OFS_TIMEOUT, 8'h02);
        clk_en <= 1'b1;
        chk_reg(`PSLT_OFS_TIMEOUT, 8'h07);
        wr(`PSLT_OFS_TIMEOUT, 8'h01);
        // Enable combinations, select codes and power requests
        for (int i = 0; i < 16; i++) begin
            g = (i < 2) ? 1'(i == 0) : 1'($urandom);
            en = (i < 2) ? 8'h60 : 8'($urandom);
            s3 = sel3[i % 3];
            s4 = sel4[(i / 3) % 3];
            wr(`PSLT_OFS_P3_PIN_SEL, s3);
            wr(`PSLT_OFS_P4_PIN_SEL, s4);
            wr(`PSLT_OFS_PORT_EN, en);
            wr(`PSLT_OFS_GLOBAL_EN, {7'h00, g});
            req3 <= 1'($urandom);
            req4 <= 1'($urandom);
            st3 <= 1'($urandom);
            st4 <= 1'($urandom);
            repeat (4) @(posedge clk);
            #1;
            `CHK(act, exp_act(g, en, s3, s4))
            `CHK(oe, exp_oe(exp_act(g, en, s3, s4), s3, s4))
            `CHK(gpio_out, ~exp_oe(exp_act(g, en, s3, s4), s3, s4))
            `CHK({ctl4, ctl3}, {req4, req3})
        end
        // Port 3 on option B hung in a stuck state: no toggle long before 100 ms
        wr(`PSLT_OFS_P3_PIN_SEL, 8'h05);
        wr(`PSLT_OFS_P4_PIN_SEL, 8'h06);
        wr(`PSLT_OFS_PORT_EN, 8'h60);
        wr(`PSLT_OFS_GLOBAL_EN, 8'h01);
        st3 <= 1'b1;
        st4 <= 1'b0;
        for (int k = 0; k < 30; k++) begin
            repeat (1000) @(posedge clk);
            #1;
            `CHK({oe, gpio_out}, 8'h96)
        end
        `CHK(evt_seen, 0)
        summarize();
    end
endmodule
